// >>> hw/urxce_pkg.sv
package urxce_pkg;
  localparam int URXCE_LEN_W = 11;
  localparam int URXCE_EP_W = 4;
  localparam int URXCE_EP_N = 16;
  localparam logic [URXCE_LEN_W-1:0] URXCE_LEN_RST = 11'h000;
  localparam logic [URXCE_LEN_W-1:0] URXCE_ISO_LEN_SHORT = 11'h001;
  localparam logic [1:0] URXCE_HS_ACK = 2'h2;
  localparam logic [1:0] URXCE_HS_NONE = 2'h0;
  typedef enum logic [1:0] {
    URXCE_ST_IDLE,
    URXCE_ST_DATA,
    URXCE_ST_DROP
  } urxce_state_e;
endpackage : urxce_pkg

// >>> hw/urxce_wr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface urxce_wr_if;
  logic wr;
  logic [7:0] data;
  logic commit;
  logic discard;
  modport src (output wr, output data, output commit, output discard);
  modport dst (input wr, input data, input commit, input discard);
endinterface : urxce_wr_if
`default_nettype wire

// >>> hw/urxce_fifo_gate.sv
`timescale 1ns/1ps
`default_nettype none
// registers each packet byte and the rollback strobe for one cycle on the way to the fifo
module urxce_fifo_gate
  import urxce_pkg::*;
#(
  parameter int LEN_W = URXCE_LEN_W
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  urxce_wr_if.dst wr_in,
  output logic fifo_wr_out,
  output logic [7:0] fifo_data_out,
  output logic fifo_rollback_out
);
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fifo_wr_out <= 1'b0;
      fifo_data_out <= 8'h00;
      fifo_rollback_out <= 1'b0;
    end else begin
      fifo_wr_out <= wr_in.wr;
      fifo_data_out <= wr_in.data;
      // a committed packet is never rolled back
      fifo_rollback_out <= wr_in.discard && !wr_in.commit;
    end
  end
endmodule : urxce_fifo_gate
`default_nettype wire

// >>> hw/urxce_rx_crc.sv
`timescale 1ns/1ps
`default_nettype none
module urxce_rx_crc
  import urxce_pkg::*;
#(
  parameter int LEN_W = URXCE_LEN_W,
  parameter int EP_N = URXCE_EP_N
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic rx_start_in,
  input wire logic [URXCE_EP_W-1:0] rx_ep_in,
  input wire logic rx_iso_in,
  input wire logic rx_byte_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_end_in,
  input wire logic rx_crc_ok_in,
  input wire logic [URXCE_EP_W-1:0] sw_ep_in,
  input wire logic sw_clr_in,
  output logic fifo_wr_out,
  output logic [7:0] fifo_data_out,
  output logic fifo_rollback_out,
  output logic [1:0] hs_out,
  output logic hs_valid_out,
  output logic pkt_done_out,
  output logic [LEN_W-1:0] pkt_len_out,
  output logic crc_err_out,
  output logic sw_crc_err_out
);
  // ----------------------------------------------------------------
  // packet tracking
  // ----------------------------------------------------------------
  urxce_state_e state;
  urxce_state_e next_state;
  logic iso;
  logic [URXCE_EP_W-1:0] ep;
  logic [LEN_W-1:0] cnt;
  logic [LEN_W-1:0] next_cnt;
  logic [EP_N-1:0] ep_err;
  logic [EP_N-1:0] next_ep_err;
  urxce_wr_if wr_bus ();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [LEN_W-1:0] inc_len(input logic [LEN_W-1:0] v);
    return LEN_W'(v + 1'b1);
  endfunction : inc_len

  function automatic logic [EP_N-1:0] ep_bit(input logic [URXCE_EP_W-1:0] e);
    return EP_N'(1) << e;
  endfunction : ep_bit

  wire logic in_pkt = (state == URXCE_ST_DATA);
  wire logic fin = in_pkt && rx_end_in;
  wire logic bad = fin && !rx_crc_ok_in;
  wire logic iso_bad = bad && iso;
  wire logic plain_bad = bad && !iso;
  // a byte may arrive together with the end strobe and still counts
  wire logic [LEN_W-1:0] fin_len = rx_byte_in ? inc_len(cnt) : cnt;
  // short count only hurts when there is a byte to drop
  wire logic [LEN_W-1:0] short_len = (fin_len >= URXCE_ISO_LEN_SHORT) ?
    LEN_W'(fin_len - URXCE_ISO_LEN_SHORT) : LEN_W'(URXCE_LEN_RST);
  wire logic [EP_N-1:0] set_mask = iso_bad ? ep_bit(ep) : '0;
  wire logic [EP_N-1:0] clr_mask = sw_clr_in ? ep_bit(sw_ep_in) : '0;

  assign wr_bus.wr = in_pkt && rx_byte_in;
  assign wr_bus.data = rx_data_in;
  assign wr_bus.commit = fin && (rx_crc_ok_in || iso);
  assign wr_bus.discard = plain_bad;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      URXCE_ST_IDLE: begin
        if (rx_start_in) begin
          next_state = URXCE_ST_DATA;
          next_cnt = URXCE_LEN_RST;
        end
      end
      URXCE_ST_DATA: begin
        if (rx_byte_in) begin
          next_cnt = inc_len(cnt);
        end
        if (rx_end_in) begin
          next_state = URXCE_ST_IDLE;
        end
      end
      default: begin
        next_state = URXCE_ST_IDLE;
      end
    endcase
  end

  // set wins over clear
  assign next_ep_err = (ep_err & ~clr_mask) | set_mask;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= URXCE_ST_IDLE;
      cnt <= URXCE_LEN_RST;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // transfer kind and endpoint are taken with the start strobe only
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      iso <= 1'b0;
      ep <= '0;
    end else if (rx_start_in && !in_pkt) begin
      iso <= rx_iso_in;
      ep <= rx_ep_in;
    end
  end

  // ----------------------------------------------------------------
  // per-endpoint crc flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ep_err <= '0;
    end else begin
      ep_err <= next_ep_err;
    end
  end

  // ----------------------------------------------------------------
  // completion report and handshake
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pkt_done_out <= 1'b0;
      pkt_len_out <= URXCE_LEN_RST;
      crc_err_out <= 1'b0;
      hs_out <= URXCE_HS_NONE;
      hs_valid_out <= 1'b0;
    end else begin
      pkt_done_out <= fin && !plain_bad;
      crc_err_out <= iso_bad;
      hs_valid_out <= fin && !iso;
      hs_out <= (fin && !iso && rx_crc_ok_in) ? URXCE_HS_ACK : URXCE_HS_NONE;
      if (fin && !plain_bad) begin
        pkt_len_out <= iso_bad ? short_len : fin_len;
      end
    end
  end

  assign sw_crc_err_out = ep_err[sw_ep_in];

  urxce_fifo_gate #(.LEN_W(LEN_W)) u_gate (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .wr_in(wr_bus),
    .fifo_wr_out(fifo_wr_out),
    .fifo_data_out(fifo_data_out),
    .fifo_rollback_out(fifo_rollback_out)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_ISO_FLAG: assert property (@(posedge clk_in) disable iff (!nrst_in)
    iso_bad |=> crc_err_out && pkt_done_out) else $error("iso crc error not flagged");

  AST_ISO_KEEP: assert property (@(posedge clk_in) disable iff (!nrst_in)
    iso_bad |=> !fifo_rollback_out) else $error("iso packet rolled back");

  AST_ROLLBACK_ONLY: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !plain_bad |=> !fifo_rollback_out) else $error("packet rolled back without cause");

  AST_ISO_SHORT: assert property (@(posedge clk_in) disable iff (!nrst_in)
    iso_bad && fin_len != 0 |=> pkt_len_out == $past(fin_len) - 1'b1)
    else $error("iso length not one short");

  AST_ALL_BYTES: assert property (@(posedge clk_in) disable iff (!nrst_in)
    in_pkt && rx_byte_in |=> fifo_wr_out && fifo_data_out == $past(rx_data_in))
    else $error("received byte not written");

  AST_NO_STRAY: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !(in_pkt && rx_byte_in) |=> !fifo_wr_out) else $error("byte written outside a packet");

  AST_DROP: assert property (@(posedge clk_in) disable iff (!nrst_in)
    plain_bad |=> fifo_rollback_out && hs_valid_out && hs_out != URXCE_HS_ACK)
    else $error("bad non-iso packet kept or acked");

  AST_GOOD_ACK: assert property (@(posedge clk_in) disable iff (!nrst_in)
    fin && !iso && rx_crc_ok_in |=> hs_valid_out && hs_out == URXCE_HS_ACK)
    else $error("good non-iso packet not acked");

  AST_HS_ONLY_PLAIN: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !(fin && !iso) |=> !hs_valid_out) else $error("handshake without non-iso end");

  AST_SILENT: assert property (@(posedge clk_in) disable iff (!nrst_in)
    plain_bad |=> !crc_err_out && !pkt_done_out) else $error("non-iso error reported");

  AST_ERR_ONLY_ISO: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !iso_bad |=> !crc_err_out) else $error("crc error raised without iso failure");

  AST_GOOD_LEN: assert property (@(posedge clk_in) disable iff (!nrst_in)
    fin && rx_crc_ok_in |=> pkt_len_out == $past(fin_len) && !crc_err_out)
    else $error("good packet length wrong");

  AST_EP_FLAG: assert property (@(posedge clk_in) disable iff (!nrst_in)
    iso_bad |=> ep_err[$past(ep)]) else $error("endpoint crc flag not set");

  AST_EP_CLEAR: assert property (@(posedge clk_in) disable iff (!nrst_in)
    sw_clr_in && !(iso_bad && sw_ep_in == ep) |=> !ep_err[$past(sw_ep_in)])
    else $error("endpoint crc flag not cleared");

  AST_LEN_HOLD: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !(fin && !plain_bad) |=> $stable(pkt_len_out)) else $error("packet length moved");
endmodule : urxce_rx_crc
`default_nettype wire

// >>> verif/urxce_host.sv
`timescale 1ns/1ps
`default_nettype none
module urxce_host (
  input wire logic clk_in,
  output logic rx_start_out,
  output logic rx_byte_out,
  output logic [7:0] rx_data_out,
  output logic rx_end_out,
  output logic rx_crc_ok_out
);
  initial begin
    {rx_start_out, rx_byte_out, rx_end_out, rx_crc_ok_out} = 4'h0;
    rx_data_out = 8'h00;
  end
  // one data packet, bytes back to back, crc verdict with the last byte
  task automatic send(input int n, input logic [7:0] d0, input logic ok);
    @(negedge clk_in);
    rx_start_out = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_in);
      rx_start_out = 1'b0;
      rx_byte_out = 1'b1;
      rx_data_out = d0 + 8'(i);
    end
    rx_end_out = 1'b1;
    rx_crc_ok_out = ok;
    @(negedge clk_in);
    {rx_start_out, rx_byte_out, rx_end_out} = 3'h0;
    // released lines show no stale value
    rx_data_out = ~rx_data_out;
    rx_crc_ok_out = ~ok;
  endtask : send
endmodule : urxce_host
`default_nettype wire

// >>> verif/urxce_rx_crc_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin fails++; \
  $display("ERROR %s exp %0h got %0h", n, e, a); end end
module urxce_rx_crc_tb;
  import urxce_pkg::*;
  logic clk_in = 0, nrst_in = 0, iso = 0, clr = 0;
  logic [3:0] ep = 4'h0;
  logic st, by, en, ok, wr, rb, hv, dn, ce, fl;
  logic [7:0] dat, fd, first, last;
  logic [1:0] hs, hsv;
  logic [10:0] len;
  logic [15:0] r = 16'h0c1d;
  int fails = 0, cmp_count = 0, nw, ndn, nce, nrb, nhv, k;
  always #25 clk_in = ~clk_in;
  urxce_host i_urxce_host (.clk_in(clk_in), .rx_start_out(st), .rx_byte_out(by),
    .rx_data_out(dat), .rx_end_out(en), .rx_crc_ok_out(ok));
  urxce_rx_crc i_urxce_rx_crc (.clk_in(clk_in), .nrst_in(nrst_in), .rx_start_in(st),
    .rx_ep_in(ep), .rx_iso_in(iso), .rx_byte_in(by), .rx_data_in(dat), .rx_end_in(en),
    .rx_crc_ok_in(ok), .sw_ep_in(ep), .sw_clr_in(clr), .fifo_wr_out(wr),
    .fifo_data_out(fd), .fifo_rollback_out(rb), .hs_out(hs), .hs_valid_out(hv),
    .pkt_done_out(dn), .pkt_len_out(len), .crc_err_out(ce), .sw_crc_err_out(fl));
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  always @(negedge clk_in) begin
    if (wr === 1'b1) begin
      if (nw == 0) first = fd;
      last = fd;
      nw++;
    end
    if (hv === 1'b1) hsv = hs;
    ndn += int'(dn === 1'b1);
    nce += int'(ce === 1'b1);
    nrb += int'(rb === 1'b1);
    nhv += int'(hv === 1'b1);
  end
  task automatic pkt(input logic i, input logic b, input int n);
    r = lfsr(r);
    iso = i;
    ep = r[3:0];
    {nw, ndn, nce, nrb, nhv} = '0;
    i_urxce_host.send(n, r[15:8], !b);
    repeat (3) @(negedge clk_in);
    `CHK("bytes", n, nw)
    `CHK("first", r[15:8], first)
    `CHK("last", 8'(r[15:8] + n - 1), last)
    `CHK("done", int'(!(b && !i)), ndn)
    if (ndn == 1) `CHK("len", 11'(b ? n - 1 : n), len)
    if (b && i) `CHK("swread", int'(len) + 1, nw)
    `CHK("crcerr", int'(b && i), nce)
    `CHK("rollback", int'(b && !i), nrb)
    `CHK("hsvalid", int'(!i), nhv)
    if (!i) `CHK("hs", (b ? URXCE_HS_NONE : URXCE_HS_ACK), hsv)
    `CHK("flag", b && i, fl)
    clr = 1'b1;
    @(negedge clk_in);
    clr = 1'b0;
    @(negedge clk_in);
    `CHK("cleared", 1'b0, fl)
  endtask : pkt
  task automatic print_verdict();
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  initial begin
    #500us;
    fails++;
    print_verdict();
  end
  initial begin
    repeat (16) @(negedge clk_in);
    nrst_in = 1'b1;
    for (int j = 0; j < 24; j++) begin
      r = lfsr(r);
      k = (j < 4) ? 1 : int'(r[4:0]) + 1;
      pkt(j[0], j[1], k);
      if (j[1] && !j[0]) begin
        repeat (2) pkt(1'b0, 1'b1, k);
        if (j == 10) begin
          nrst_in = 1'b0;
          @(negedge clk_in);
          `CHK("rstlen", URXCE_LEN_RST, len)
          `CHK("rstflag", 1'b0, fl)
          repeat (3) @(negedge clk_in);
          nrst_in = 1'b1;
        end
        pkt(1'b0, 1'b0, k);
      end
    end
    print_verdict();
  end
endmodule : urxce_rx_crc_tb
`default_nettype wire
